// File: logic/cct_defines.svh
// constants of the cascadable counter/timer block
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

`define CCT_OSC_HZ       25_000_000
`define CCT_PRE_AB_W     6
`define CCT_PRE_C_W      4
`define CCT_CNT_W        32
`define CCT_DIV_W        3
`define CCT_CHAIN_LO     0
`define CCT_CHAIN_HI     1
`define CCT_PRE_C_LO     2
`define CCT_PRE_C_HI     5
`define CCT_CHAIN_8_8_32   2'h0
`define CCT_CHAIN_16_16_16 2'h1
`define CCT_CHAIN_8_24_16  2'h2
`define CCT_CHAIN_8_16_24  2'h3
`define CCT_MASK_8       32'h0000_00FF
`define CCT_MASK_16      32'h0000_FFFF
`define CCT_MASK_24      32'h00FF_FFFF
`define CCT_MASK_32      32'hFFFF_FFFF
`define CCT_DIV4_PHASE   2'h3
`define CCT_DIV8_PHASE   3'h7

`endif

// File: logic/cct_pkg.sv
// types of the cascadable counter/timer block
package cct_pkg;

  typedef enum logic [2:0] {
    CCT_CMD_NOP     = 3'h0,
    CCT_CMD_START   = 3'h1,
    CCT_CMD_STOP    = 3'h2,
    CCT_CMD_RESUME  = 3'h3,
    CCT_CMD_RESTART = 3'h4
  } cct_cmd_type;

  typedef enum logic [1:0] {
    CCT_EXT_CLOCK    = 2'h0,
    CCT_EXT_RETRIG   = 2'h1,
    CCT_EXT_NORETRIG = 2'h2,
    CCT_EXT_GATE     = 2'h3
  } cct_ext_mode_type;

  typedef enum logic {
    CCT_ST_IDLE = 1'b0,
    CCT_ST_RUN  = 1'b1
  } cct_state_type;

  typedef struct packed {
    logic [5:0]       timer_a_pre;
    logic [5:0]       timer_b_pre;
    logic [5:0]       timer_c_prescale_reg;
    logic [15:0]      init_a;
    logic [23:0]      init_b;
    logic [31:0]      init_c;
    logic             cont_a;
    logic             cont_b;
    logic             cont_c;
    logic             b_ext_src;
    cct_ext_mode_type b_ext_mode;
    logic             cascade_en;
    logic             out_sel_b;
    logic             c_div8;
  } cct_cfg_type;

endpackage

// File: logic/cct_prescale.sv
// programmable prescaler: one pulse out per div_i ticks in, 0 means 2**W
`timescale 1ns/1ns
module cct_prescale #(
  parameter int W = 6
) (
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic         tick_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] div_i,
  output logic              pulse_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         wrap;

  assign wrap    = (cnt_reg == W'(div_i - W'(1)));
  assign pulse_o = tick_i && wrap;

  always_comb begin
    cnt_next = cnt_reg;
    if (clear_i) begin
      cnt_next = '0;
    end else if (tick_i) begin
      cnt_next = wrap ? '0 : W'(cnt_reg + W'(1));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // cct_prescale

// File: logic/cct_down_cnt.sv
// down counter with start/stop/resume/restart, single-pass or continuous
`timescale 1ns/1ns
module cct_down_cnt (
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  tick_i,
  input  wire cct_pkg::cct_cmd_type  cmd_i,
  input  wire logic                  cont_i,
  input  wire logic [31:0]           init_i,
  input  wire logic [31:0]           mask_i,
  output logic [31:0]                count_o,
  output logic                       tc_o,
  output logic                       run_o
);
  import cct_pkg::*;

  cct_state_type st_reg;
  cct_state_type st_next;
  logic [31:0]   cnt_reg;
  logic [31:0]   cnt_next;
  logic          tc_reg;
  logic          tc_next;
  logic [31:0]   load_val;

  assign load_val = init_i & mask_i;
  assign count_o  = cnt_reg;
  assign tc_o     = tc_reg;
  assign run_o    = (st_reg == CCT_ST_RUN);

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    tc_next  = 1'b0;
    unique case (cmd_i)
      CCT_CMD_START: begin // R1
        st_next = CCT_ST_RUN;
        if (cnt_reg == 32'h0000_0000) begin
          cnt_next = load_val;
        end
      end
      CCT_CMD_STOP: begin // R1
        st_next = CCT_ST_IDLE;
      end
      CCT_CMD_RESUME: begin // R1
        st_next = CCT_ST_RUN;
      end
      CCT_CMD_RESTART: begin // R1
        st_next  = CCT_ST_RUN;
        cnt_next = load_val;
      end
      CCT_CMD_NOP: begin
        if (st_reg == CCT_ST_RUN && tick_i) begin
          if ((cnt_reg & mask_i) <= 32'h0000_0001) begin
            tc_next = 1'b1;
            if (cont_i) begin
              cnt_next = load_val; // R2
            end else begin
              cnt_next = 32'h0000_0000; // R2
              st_next  = CCT_ST_IDLE;
            end
          end else begin
            // lower stages borrow from upper ones as one long counter
            cnt_next = (cnt_reg - 32'h0000_0001) & mask_i; // R19
          end
        end
      end
      default: begin
        st_next = st_reg;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_reg  <= CCT_ST_IDLE;
      cnt_reg <= 32'h0000_0000;
      tc_reg  <= 1'b0;
    end else begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
      tc_reg  <= tc_next;
    end
  end

  AST_SINGLE_HALT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R2
    (cmd_i == CCT_CMD_NOP && run_o && tick_i && !cont_i && (cnt_reg & mask_i) <= 32'h0000_0001)
    |=> (!run_o && cnt_reg == 32'h0000_0000 && tc_o))
    else $error("single pass did not halt at zero");

  AST_RELOAD: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R2
    (cmd_i == CCT_CMD_NOP && run_o && tick_i && cont_i && (cnt_reg & mask_i) <= 32'h0000_0001)
    |=> (run_o && cnt_reg == $past(load_val) && tc_o))
    else $error("continuous mode did not reload");

  AST_READ_STABLE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R3
    (cmd_i == CCT_CMD_NOP && !tick_i) |=> ($stable(cnt_reg) && $stable(st_reg)))
    else $error("count changed without tick or command");

endmodule // cct_down_cnt

// File: logic/cct_timers.sv
// three cascadable counter/timers with capture and timer output pin
//
// Function
// R1: start, stop, resume, restart commands per counter
// R2: single-pass halts at zero; continuous reloads
// R3: counter reads never disturb count or mode
// R4: timer_b clock: osc/4 or external pin
// R5: external input as clock, trigger or gate
// R6: cascade: timer_a output clocks timer_b
// R7: output pin carries timer_a or timer_b
// R8: timer_a: 6-bit prescaler, 16-bit counter
// R9: timer_b: 6-bit prescaler, 16-bit counter
// R10: timer_c: 4-bit prescaler, 16-bit counter, capture
// R11: prescale bits 1:0 select chain lengths
// R12: each chain code sets three counter lengths
// R13: timer_c clock osc/2, osc/8 only when 16-bit
// R14: capture falling edge latches timer_c 16 bits
// R15: capture always on, capture value read-only
// R16: capture edge raises an interrupt request
// R17: counters keep running in halt mode
// R18: stop mode freezes counters and prescalers
// R19: chained counters act as one longer counter
`timescale 1ns/1ns
`include "cct_defines.svh"
module cct_timers (
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  stop_mode_i,
  input  wire logic                  ext_timer_input_pin_i,
  input  wire logic                  capture_edge_pin_i,
  input  wire cct_pkg::cct_cfg_type  cfg_i,
  input  wire cct_pkg::cct_cmd_type  cmd_a_i,
  input  wire cct_pkg::cct_cmd_type  cmd_b_i,
  input  wire cct_pkg::cct_cmd_type  cmd_c_i,
  output logic                       timer_output_pin_o,
  output logic [15:0]                count_a_o,
  output logic [23:0]                count_b_o,
  output logic [31:0]                count_c_o,
  output logic [15:0]                capture_o,
  output logic                       capture_irq_o
);
  import cct_pkg::*;

  // ---------------------------------------------------------------
  // chain length selection
  // ---------------------------------------------------------------
  logic [1:0]  chain_sel;
  logic [31:0] mask_a;
  logic [31:0] mask_b;
  logic [31:0] mask_c;
  logic        c_is_16;

  assign chain_sel = cfg_i.timer_c_prescale_reg[`CCT_CHAIN_HI:`CCT_CHAIN_LO]; // R11

  always_comb begin
    mask_a = `CCT_MASK_8;
    mask_b = `CCT_MASK_16;
    mask_c = `CCT_MASK_16;
    unique case (chain_sel) // R12
      `CCT_CHAIN_8_8_32: begin
        mask_b = `CCT_MASK_8;
        mask_c = `CCT_MASK_32;
      end
      `CCT_CHAIN_16_16_16: begin
        mask_a = `CCT_MASK_16;
      end
      `CCT_CHAIN_8_24_16: begin
        mask_b = `CCT_MASK_24;
      end
      `CCT_CHAIN_8_16_24: begin
        mask_c = `CCT_MASK_24;
      end
    endcase
  end

  assign c_is_16 = (mask_c == `CCT_MASK_16);

  // ---------------------------------------------------------------
  // oscillator dividers
  // ---------------------------------------------------------------
  // they run on the oscillator whatever the cpu does, so halt
  // leaves them alone; only stop freezes them
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic       run_ok;
  logic       tick4;
  logic       tick_c;

  assign run_ok = !stop_mode_i; // R17 R18

  always_comb begin
    div_next = div_reg;
    if (run_ok) begin
      div_next = 3'(div_reg + 3'h1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick4  = run_ok && (div_reg[1:0] == `CCT_DIV4_PHASE);
  // osc/8 only honoured while timer_c is 16 bits long
  assign tick_c = run_ok && ((cfg_i.c_div8 && c_is_16) ? (div_reg == `CCT_DIV8_PHASE)
                                                        : div_reg[0]); // R13

  // ---------------------------------------------------------------
  // external timer input
  // ---------------------------------------------------------------
  logic ext_prev_reg;
  logic ext_prev_next;
  logic ext_rise;
  logic trig;
  logic b_run;

  always_comb begin
    ext_prev_next = ext_prev_reg;
    if (run_ok) begin
      ext_prev_next = ext_timer_input_pin_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_prev_next;
    end
  end

  assign ext_rise = run_ok && ext_timer_input_pin_i && !ext_prev_reg;

  // triggers restart timer_b from its initial value
  always_comb begin
    trig = 1'b0;
    if (cfg_i.b_ext_src && !cfg_i.cascade_en) begin
      unique case (cfg_i.b_ext_mode) // R5
        CCT_EXT_RETRIG:   trig = ext_rise;
        CCT_EXT_NORETRIG: trig = ext_rise && !b_run;
        CCT_EXT_CLOCK:    trig = 1'b0;
        CCT_EXT_GATE:     trig = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timer_b clock source
  // ---------------------------------------------------------------
  logic tc_a;
  logic src_b;

  always_comb begin
    src_b = tick4; // R4
    if (cfg_i.cascade_en) begin
      src_b = run_ok && tc_a; // R6 R18
    end else if (cfg_i.b_ext_src) begin
      unique case (cfg_i.b_ext_mode) // R5
        CCT_EXT_CLOCK:    src_b = ext_rise; // R4
        CCT_EXT_GATE:     src_b = tick4 && ext_timer_input_pin_i;
        CCT_EXT_RETRIG:   src_b = tick4;
        CCT_EXT_NORETRIG: src_b = tick4;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // commands, gated off while stopped
  // ---------------------------------------------------------------
  cct_cmd_type cmd_a;
  cct_cmd_type cmd_b;
  cct_cmd_type cmd_c;

  assign cmd_a = run_ok ? cmd_a_i : CCT_CMD_NOP; // R18
  assign cmd_b = !run_ok ? CCT_CMD_NOP : (trig ? CCT_CMD_RESTART : cmd_b_i);
  assign cmd_c = run_ok ? cmd_c_i : CCT_CMD_NOP; // R18

  // ---------------------------------------------------------------
  // prescalers
  // ---------------------------------------------------------------
  logic pre_a;
  logic pre_b;
  logic pre_c;

  cct_prescale #(.W(`CCT_PRE_AB_W)) u_pre_a ( // R8
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (tick4),
    .clear_i   (cmd_a == CCT_CMD_RESTART),
    .div_i     (cfg_i.timer_a_pre),
    .pulse_o   (pre_a)
  );

  cct_prescale #(.W(`CCT_PRE_AB_W)) u_pre_b ( // R9
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (src_b),
    .clear_i   (cmd_b == CCT_CMD_RESTART),
    .div_i     (cfg_i.timer_b_pre),
    .pulse_o   (pre_b)
  );

  cct_prescale #(.W(`CCT_PRE_C_W)) u_pre_c ( // R10
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (tick_c),
    .clear_i   (cmd_c == CCT_CMD_RESTART),
    .div_i     (cfg_i.timer_c_prescale_reg[`CCT_PRE_C_HI:`CCT_PRE_C_LO]),
    .pulse_o   (pre_c)
  );

  // ---------------------------------------------------------------
  // down counters
  // ---------------------------------------------------------------
  logic [31:0] cnt_a;
  logic [31:0] cnt_b;
  logic [31:0] cnt_c;
  logic        tc_b;

  cct_down_cnt u_cnt_a ( // R8
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (pre_a),
    .cmd_i     (cmd_a),
    .cont_i    (cfg_i.cont_a),
    .init_i    ({16'h0000, cfg_i.init_a}),
    .mask_i    (mask_a),
    .count_o   (cnt_a),
    .tc_o      (tc_a),
    .run_o     ()
  );

  cct_down_cnt u_cnt_b ( // R9
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (pre_b),
    .cmd_i     (cmd_b),
    .cont_i    (cfg_i.cont_b),
    .init_i    ({8'h00, cfg_i.init_b}),
    .mask_i    (mask_b),
    .count_o   (cnt_b),
    .tc_o      (tc_b),
    .run_o     (b_run)
  );

  cct_down_cnt u_cnt_c ( // R10
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .tick_i    (pre_c),
    .cmd_i     (cmd_c),
    .cont_i    (cfg_i.cont_c),
    .init_i    (cfg_i.init_c),
    .mask_i    (mask_c),
    .count_o   (cnt_c),
    .tc_o      (),
    .run_o     ()
  );

  // read-only views of the live counts
  assign count_a_o = cnt_a[15:0]; // R3
  assign count_b_o = cnt_b[23:0]; // R3
  assign count_c_o = cnt_c; // R3

  // ---------------------------------------------------------------
  // timer output pin and capture
  // ---------------------------------------------------------------
  logic        tout_reg;
  logic        tout_next;
  logic        cap_prev_reg;
  logic        cap_prev_next;
  logic [15:0] cap_reg;
  logic [15:0] cap_next;
  logic        irq_reg;
  logic        irq_next;
  logic        cap_fall;

  assign cap_fall = run_ok && cap_prev_reg && !capture_edge_pin_i;

  always_comb begin
    tout_next     = tout_reg;
    cap_prev_next = cap_prev_reg;
    cap_next      = cap_reg;
    irq_next      = 1'b0;
    if (cfg_i.out_sel_b ? tc_b : tc_a) begin
      tout_next = !tout_reg; // R7
    end
    if (run_ok) begin
      cap_prev_next = capture_edge_pin_i;
    end
    if (cap_fall) begin
      cap_next = cnt_c[15:0]; // R14 R15
      irq_next = 1'b1; // R16
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tout_reg     <= 1'b0;
      cap_prev_reg <= 1'b1;
      cap_reg      <= 16'h0000;
      irq_reg      <= 1'b0;
    end else begin
      tout_reg     <= tout_next;
      cap_prev_reg <= cap_prev_next;
      cap_reg      <= cap_next;
      irq_reg      <= irq_next;
    end
  end

  assign timer_output_pin_o = tout_reg;
  assign capture_o          = cap_reg;
  assign capture_irq_o      = irq_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_CAPTURE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R14
    (run_ok && $fell(capture_edge_pin_i)) |=> (capture_o == $past(cnt_c[15:0])))
    else $error("capture did not latch timer_c");

  AST_CAP_IRQ: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R16
    capture_irq_o |-> ($past(capture_edge_pin_i, 2) && !$past(capture_edge_pin_i)))
    else $error("capture interrupt without falling edge");

  AST_FREEZE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R18
    (stop_mode_i && $past(stop_mode_i)) |-> ($stable(cnt_a) && $stable(cnt_b)
                                             && $stable(cnt_c) && $stable(div_reg)))
    else $error("counters moved in stop mode");

  AST_TOUT: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R7
    (cfg_i.out_sel_b ? tc_b : tc_a) |=> (timer_output_pin_o != $past(timer_output_pin_o)))
    else $error("timer output did not toggle");

  AST_CASCADE: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R6
    (cfg_i.cascade_en && !tc_a) |-> !src_b)
    else $error("timer_b clocked without timer_a output");

  AST_C_DIV: assert property (@(posedge ref_clk_i) disable iff (srst_i) // R13
    (!c_is_16 && run_ok) |-> (tick_c == div_reg[0]))
    else $error("osc/8 used while timer_c not 16 bits");

endmodule // cct_timers

// File: testbench/cct_pin_model.sv
// far-side model of the external timer input and capture pins
`timescale 1ns/1ns
module cct_pin_model (
  input  wire logic ref_clk_i,
  output logic      ext_pin_o,
  output logic      cap_pin_o
);
  initial begin
    ext_pin_o = 1'b0;
    cap_pin_o = 1'b1;
  end

  // ------------------------------
  // pin drivers
  // ------------------------------
  task automatic step();
    @(posedge ref_clk_i);
    #2;
  endtask

  // each level stands two cycles so the synchroniser cannot miss it
  task automatic ext_pulses(input int n);
    repeat (n) begin
      step();
      ext_pin_o = 1'b1;
      repeat (2) step();
      ext_pin_o = 1'b0;
      step();
    end
  endtask

  task automatic ext_level(input logic v);
    step();
    ext_pin_o = v;
  endtask

  task automatic cap_fall();
    step();
    cap_pin_o = 1'b0;
    repeat (2) step();
    cap_pin_o = 1'b1;
    step();
  endtask
endmodule // cct_pin_model

// File: testbench/cct_timers_tb_top.sv
// self-checking bench for the cascadable counter/timers
`timescale 1ns/1ns
module cct_timers_tb_top;
  import cct_pkg::*;
  logic        ref_clk_i;
  logic        srst_i;
  logic        stop_mode_i;
  logic        ext_pin;
  logic        cap_pin;
  cct_cfg_type cfg;
  cct_cmd_type cmd_a;
  cct_cmd_type cmd_b;
  cct_cmd_type cmd_c;
  logic        out_pin;
  logic        out_q;
  logic [15:0] count_a;
  logic [23:0] count_b;
  logic [31:0] count_c;
  logic [15:0] capture;
  logic        irq;
  logic [31:0] v0;
  int          num_errors;
  int          checks;
  int          irqs;
  int          toggles;
  logic [31:0] mask_a [4] = '{32'h0000_00FF, 32'h0000_FFFF, 32'h0000_00FF, 32'h0000_00FF};
  logic [31:0] mask_b [4] = '{32'h0000_00FF, 32'h0000_FFFF, 32'h00FF_FFFF, 32'h0000_FFFF};
  logic [31:0] mask_c [4] = '{32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h00FF_FFFF};

  cct_pin_model i_pins (
    .ref_clk_i (ref_clk_i),
    .ext_pin_o (ext_pin),
    .cap_pin_o (cap_pin)
  );

  cct_timers i_dut (
    .ref_clk_i             (ref_clk_i),
    .srst_i                (srst_i),
    .stop_mode_i           (stop_mode_i),
    .ext_timer_input_pin_i (ext_pin),
    .capture_edge_pin_i    (cap_pin),
    .cfg_i                 (cfg),
    .cmd_a_i               (cmd_a),
    .cmd_b_i               (cmd_b),
    .cmd_c_i               (cmd_c),
    .timer_output_pin_o    (out_pin),
    .count_a_o             (count_a),
    .count_b_o             (count_b),
    .count_c_o             (count_c),
    .capture_o             (capture),
    .capture_irq_o         (irq)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) begin
    if (irq === 1'b1) irqs++;
    if (out_pin !== out_q) toggles++;
    out_q <= out_pin;
  end

  // ------------------------------
  // access and compare tasks
  // ------------------------------
  function automatic logic [31:0] cnt(input int s);
    case (s)
      0: return {16'h0000, count_a};
      1: return {8'h00, count_b};
      default: return count_c;
    endcase
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk({31'h0000_0000, c}, 32'h0000_0001);
  endtask

  // s selects timer a, b, c, or all three with 3
  task automatic cmd(input int s, input cct_cmd_type c);
    wt(1);
    cmd_a = (s == 0 || s == 3) ? c : CCT_CMD_NOP;
    cmd_b = (s == 1 || s == 3) ? c : CCT_CMD_NOP;
    cmd_c = (s == 2 || s == 3) ? c : CCT_CMD_NOP;
    wt(1);
    cmd_a = CCT_CMD_NOP;
    cmd_b = CCT_CMD_NOP;
    cmd_c = CCT_CMD_NOP;
  endtask

  // decrements seen over a window that is a multiple of every divider
  task automatic rate(input int s, input logic [31:0] exp);
    logic [31:0] v;
    v = cnt(s);
    wt(96);
    chk(v - cnt(s), exp);
  endtask

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    srst_i = 1'b1;
    stop_mode_i = 1'b0;
    cfg = '0;
    cmd_a = CCT_CMD_NOP;
    cmd_b = CCT_CMD_NOP;
    cmd_c = CCT_CMD_NOP;
    out_q = 1'b0;
    wt(6);
    srst_i = 1'b0;
    cfg.init_a = 16'hFFFF;
    cfg.init_b = 24'hFF_FFFF;
    cfg.init_c = 32'hFFFF_FFFF;
    for (int k = 0; k < 4; k++) begin
      cfg.timer_c_prescale_reg = {4'h0, 2'(k)};
      cmd(3, CCT_CMD_RESTART);
      chk(cnt(0), mask_a[k]);
      chk(cnt(1), mask_b[k]);
      chk(cnt(2), mask_c[k]);
    end
    cfg.timer_c_prescale_reg = {4'h1, 2'h1};
    cfg.init_a = 16'h03E8;
    cfg.init_b = 24'h00_03E8;
    cfg.init_c = 32'h0000_03E8;
    cfg.timer_a_pre = 6'h02;
    cfg.timer_b_pre = 6'h01;
    {cfg.cont_a, cfg.cont_b, cfg.cont_c, cfg.c_div8} = 4'hF;
    cmd(3, CCT_CMD_RESTART);
    rate(0, 32'h0000_000C);
    rate(1, 32'h0000_0018);
    rate(2, 32'h0000_000C);
    cfg.c_div8 = 1'b0;
    cmd(2, CCT_CMD_RESTART);
    rate(2, 32'h0000_0030);
    cfg.timer_c_prescale_reg = {4'h3, 2'h1};
    cmd(2, CCT_CMD_RESTART);
    rate(2, 32'h0000_0010);
    cfg.timer_c_prescale_reg = {4'h1, 2'h0};
    cfg.c_div8 = 1'b1;
    cmd(2, CCT_CMD_RESTART);
    rate(2, 32'h0000_0030);
    cfg.timer_c_prescale_reg = {4'h1, 2'h1};
    cfg.c_div8 = 1'b0;
    cfg.timer_a_pre = 6'h01;
    cfg.init_a = 16'h0003;
    cfg.cont_a = 1'b0;
    cmd(0, CCT_CMD_RESTART);
    chk(cnt(0), 32'h0000_0003);
    wt(40);
    chk(cnt(0), 32'h0000_0000);
    cmd(0, CCT_CMD_START);
    chk(cnt(0), 32'h0000_0003);
    cmd(0, CCT_CMD_STOP);
    v0 = cnt(0);
    wt(40);
    chk(cnt(0), v0);
    cmd(0, CCT_CMD_RESUME);
    wt(40);
    chk(cnt(0), 32'h0000_0000);
    cfg.cont_a = 1'b1;
    cmd(0, CCT_CMD_RESTART);
    repeat (32) begin
      wt(1);
      ok(cnt(0) != 32'h0000_0000 && cnt(0) <= 32'h0000_0003);
    end
    cfg.init_a = 16'h03E8;
    cmd(0, CCT_CMD_RESTART);
    chk(cnt(0), 32'h0000_03E8);
    stop_mode_i = 1'b1;
    v0 = cnt(0);
    cmd(0, CCT_CMD_RESTART);
    i_pins.cap_fall();
    wt(40);
    chk(cnt(0), v0);
    chk(32'(irqs), 32'h0000_0000);
    stop_mode_i = 1'b0;
    wt(40);
    ok(cnt(0) != v0);
    cmd(2, CCT_CMD_RESTART);
    for (int k = 0; k < 2; k++) begin
      wt(20);
      cmd(2, CCT_CMD_STOP);
      v0 = 32'(irqs);
      i_pins.cap_fall();
      chk({16'h0000, capture}, {16'h0000, count_c[15:0]});
      chk(32'(irqs) - v0, 32'h0000_0001);
      cmd(2, CCT_CMD_RESUME);
    end
    cfg.b_ext_src = 1'b1;
    cfg.b_ext_mode = CCT_EXT_CLOCK;
    cmd(1, CCT_CMD_RESTART);
    i_pins.ext_pulses(5);
    wt(4);
    chk(cnt(1), 32'h0000_03E3);
    cfg.b_ext_mode = CCT_EXT_GATE;
    cmd(1, CCT_CMD_RESTART);
    i_pins.ext_level(1'b1);
    wt(95);
    i_pins.ext_level(1'b0);
    wt(8);
    chk(cnt(1), 32'h0000_03D0);
    cfg.b_ext_mode = CCT_EXT_RETRIG;
    cmd(1, CCT_CMD_RESTART);
    wt(96);
    i_pins.ext_pulses(1);
    ok(cnt(1) > 32'h0000_03DE);
    cfg.b_ext_mode = CCT_EXT_NORETRIG;
    cmd(1, CCT_CMD_RESTART);
    wt(96);
    i_pins.ext_pulses(1);
    ok(cnt(1) < 32'h0000_03DE);
    cfg.b_ext_src = 1'b0;
    cfg.cascade_en = 1'b1;
    cfg.init_a = 16'h0002;
    cmd(3, CCT_CMD_RESTART);
    rate(1, 32'h0000_000C);
    v0 = 32'(toggles);
    wt(96);
    chk(32'(toggles) - v0, 32'h0000_000C);
    cfg.out_sel_b = 1'b1;
    cfg.init_b = 24'h00_0002;
    cmd(1, CCT_CMD_RESTART);
    wt(4);
    v0 = 32'(toggles);
    wt(96);
    chk(32'(toggles) - v0, 32'h0000_0006);
    cfg.timer_c_prescale_reg = {4'h1, 2'h0};
    cfg.init_c = 32'h0001_0002;
    cmd(2, CCT_CMD_RESTART);
    wt(8);
    chk(cnt(2), 32'h0000_FFFE);
    wrap_up();
  end

  initial begin
    repeat (10000) @(posedge ref_clk_i);
    num_errors++;
    wrap_up();
  end
endmodule // cct_timers_tb_top
